// *** pkg/sdr_pkg.sv ***
`default_nettype none
// ==========================================================================
// shared constants of the data-ready serial block
package sdr_pkg;
  localparam int          SDR_DATA_W        = 16;
  localparam int          SDR_BUF_DEPTH     = 2;
  // command code that fetches the latest result; plain default value
  localparam logic [7:0]  SDR_CMD_READ_DATA = 8'h10;
  localparam logic [4:0]  SDR_CMD_LAST_BIT  = 5'h07;
  localparam logic [4:0]  SDR_READ_LAST_BIT = 5'h0F;
  localparam logic [15:0] SDR_RST_RESULT    = 16'h0000;
  localparam logic [15:0] SDR_IDLE_SHIFT    = 16'hFFFF;
  localparam logic [2:0]  SDR_RST_CURRENT   = 3'h0;
  localparam logic [1:0]  SDR_RST_SYNC_HIGH = 2'h3;
  localparam logic [1:0]  SDR_RST_SYNC_LOW  = 2'h0;
  localparam logic [1:0]  SDR_BUF_FULL      = 2'h2;
  localparam logic [1:0]  SDR_BUF_EMPTY     = 2'h0;

  typedef enum logic [1:0] {
    SDR_WAIT   = 2'b00,
    SDR_DIRECT = 2'b01,
    SDR_CMD    = 2'b10,
    SDR_RDATA  = 2'b11
  } sdr_phase_t;
endpackage : sdr_pkg
`default_nettype wire

// *** pkg/sdr_stream_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// valid/ready word stream between the result buffer and the serial core
interface sdr_stream_if;
  logic                          valid;
  logic                          ready;
  logic [sdr_pkg::SDR_DATA_W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sdr_stream_if
`default_nettype wire

// *** rtl/sdr_ready_core.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - the combined data/ready pin is released whenever chip select is high.
// - with chip select high the combined pin never reports new data, in either ready mode.
// - the dedicated ready pin is always driven, chip select high or low.
// - in ready mode 1 the combined pin is driven to a firm level as soon as chip select falls.
// - on that fall the combined pin shows low when an unread result waits and high otherwise.
// - the read-data command returns a clean copy of the latest result when it is sent in the command phase.
// - temperature-sensor mode set to 1 switches conversions to die temperature.
// - results are passed on unchanged, with no cold-junction correction.
// - both excitation sources take one shared three-bit current setting.
// - ready mode 1 signals on both pins, ready mode 0 on the dedicated pin only.
// - the serial clock idles low, data change on rising and are sampled on falling edges.
// - the dedicated ready pin goes low when a new result is taken from the buffer, which happens only while chip select is high.
// ==========================================================================
module sdr_ready_core (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_csn_n,
  input  wire logic        i_spi_din,
  output logic             o_combined_dataout_ready_pin,
  output logic             o_combined_dataout_ready_pin_oe,
  output logic             o_dedicated_ready_pin_n,
  input  wire logic        i_ready_indication_mode,
  input  wire logic        i_temp_sensor_mode,
  input  wire logic [2:0]  i_excitation_current_setting,
  output logic             o_temp_sensor_select,
  output logic [2:0]       o_excitation_source_one,
  output logic [2:0]       o_excitation_source_two,
  input  wire logic        i_conv_valid,
  input  wire logic [15:0] i_conv_data,
  output logic             o_conv_ready
);

  typedef struct packed {
    logic [1:0]          csn_s;
    logic [1:0]          sclk_s;
    logic [1:0]          din_s;
    logic                sclk_d;
    sdr_pkg::sdr_phase_t phase;
    logic [4:0]          bit_cnt;
    logic [7:0]          cmd;
    logic [15:0]         out_shift;
    logic [15:0]         latest;
    logic                pending;
    logic                dout_bit;
    logic                dout_oe;
    logic                ready_n;
    logic                temp_sel;
    logic [2:0]          exc_one;
    logic [2:0]          exc_two;
  } sdr_core_t;

  sdr_core_t    q;
  sdr_core_t    next_q;
  sdr_stream_if in_if ();
  sdr_stream_if out_if ();

  logic       sel;
  logic       rise;
  logic       fall;
  logic       take;
  logic       clr;
  logic [7:0] cmd_now;

  // ========================================================================
  // result buffer: a stall while selected backs up to the converter
  assign in_if.valid  = i_conv_valid;
  assign in_if.data   = i_conv_data;
  assign o_conv_ready = in_if.ready;
  // results only move while deselected, so a read never sees a torn word
  assign out_if.ready = (q.phase == sdr_pkg::SDR_WAIT) & q.csn_s[1];

  sdr_result_buf u_buf (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .s_in       (in_if),
    .s_out      (out_if)
  );

  // ========================================================================
  // serial engine
  always_comb begin
    next_q        = q;
    next_q.csn_s  = {q.csn_s[0], i_spi_csn_n};
    next_q.sclk_s = {q.sclk_s[0], i_spi_sclk};
    next_q.din_s  = {q.din_s[0], i_spi_din};
    next_q.sclk_d = q.sclk_s[1];
    sel     = ~q.csn_s[1];
    rise    = q.sclk_s[1] & ~q.sclk_d;
    fall    = ~q.sclk_s[1] & q.sclk_d;
    take    = out_if.valid & out_if.ready;
    clr     = 1'b0;
    cmd_now = {q.cmd[6:0], q.din_s[1]};
    if (take) begin
      next_q.latest = out_if.data;
    end
    unique case (q.phase)
      sdr_pkg::SDR_WAIT: begin
        if (sel) begin
          next_q.bit_cnt   = '0;
          next_q.cmd       = '0;
          next_q.phase     = q.pending ? sdr_pkg::SDR_DIRECT : sdr_pkg::SDR_CMD;
          next_q.out_shift = q.pending ? q.latest : sdr_pkg::SDR_IDLE_SHIFT;
          // mode 1 shows the ready state at once, mode 0 leaves the line high
          next_q.dout_bit  = i_ready_indication_mode ? ~q.pending : 1'b1;
        end
      end
      sdr_pkg::SDR_DIRECT,
      sdr_pkg::SDR_CMD,
      sdr_pkg::SDR_RDATA: begin
        if (!sel) begin
          next_q.phase = sdr_pkg::SDR_WAIT;
        end else begin
          if (rise) begin
            // ones refill the shifter so flush clocks leave the pin high
            next_q.dout_bit  = q.out_shift[15];
            next_q.out_shift = {q.out_shift[14:0], 1'b1};
          end
          if (fall) begin
            next_q.bit_cnt = q.bit_cnt + 5'h01;
            next_q.cmd     = cmd_now;
            if (q.phase != sdr_pkg::SDR_CMD && q.bit_cnt == sdr_pkg::SDR_READ_LAST_BIT) begin
              clr            = 1'b1;
              next_q.phase   = sdr_pkg::SDR_CMD;
              next_q.bit_cnt = '0;
            end else if (q.phase == sdr_pkg::SDR_CMD && q.bit_cnt == sdr_pkg::SDR_CMD_LAST_BIT) begin
              next_q.bit_cnt = '0;
              if (cmd_now == sdr_pkg::SDR_CMD_READ_DATA) begin
                next_q.phase     = sdr_pkg::SDR_RDATA;
                next_q.out_shift = q.latest;
              end
            end
          end
        end
      end
    endcase
    // a new result outranks the clear of the old one
    next_q.pending  = (q.pending & ~clr) | take;
    next_q.dout_oe  = sel;
    next_q.ready_n  = ~next_q.pending;
    next_q.temp_sel = i_temp_sensor_mode;
    next_q.exc_one  = i_excitation_current_setting;
    next_q.exc_two  = i_excitation_current_setting;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q           <= '0;
      q.csn_s     <= sdr_pkg::SDR_RST_SYNC_HIGH;
      q.sclk_s    <= sdr_pkg::SDR_RST_SYNC_LOW;
      q.phase     <= sdr_pkg::SDR_WAIT;
      q.out_shift <= sdr_pkg::SDR_IDLE_SHIFT;
      q.latest    <= sdr_pkg::SDR_RST_RESULT;
      q.dout_bit  <= 1'b1;
      q.ready_n   <= 1'b1;
      q.exc_one   <= sdr_pkg::SDR_RST_CURRENT;
      q.exc_two   <= sdr_pkg::SDR_RST_CURRENT;
    end else begin
      q <= next_q;
    end
  end

  assign o_combined_dataout_ready_pin    = q.dout_bit;
  assign o_combined_dataout_ready_pin_oe = q.dout_oe;
  assign o_dedicated_ready_pin_n         = q.ready_n;
  assign o_temp_sensor_select            = q.temp_sel;
  assign o_excitation_source_one         = q.exc_one;
  assign o_excitation_source_two         = q.exc_two;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_select;
    $fell(q.csn_s[1]) && (q.phase == sdr_pkg::SDR_WAIT);
  endsequence

  sequence s_deselected;
    q.csn_s[1] [*2];
  endsequence

  sequence s_rdata_hit;
    fall && (q.phase == sdr_pkg::SDR_CMD) && (q.bit_cnt == sdr_pkg::SDR_CMD_LAST_BIT)
      && (cmd_now == sdr_pkg::SDR_CMD_READ_DATA) && sel;
  endsequence

  AST_RELEASE_WHEN_HIGH: assert property (
    q.csn_s[1] |=> !q.dout_oe)
    else $error("combined pin driven while deselected");

  AST_NO_READY_WHEN_HIGH: assert property (
    s_deselected |-> !q.dout_oe && (q.phase == sdr_pkg::SDR_WAIT))
    else $error("combined pin signals while deselected");

  AST_DEDICATED_DRIVEN: assert property (
    q.csn_s[1] && q.pending |=> !q.ready_n)
    else $error("dedicated ready lost while deselected");

  AST_MODE1_FIRM_LEVEL: assert property (
    s_select ##0 i_ready_indication_mode |=> q.dout_oe && (q.dout_bit == !$past(q.pending)))
    else $error("mode 1 select gave wrong ready level");

  AST_MODE1_LOW_ON_DATA: assert property (
    s_select ##0 (i_ready_indication_mode && q.pending) |=> !q.dout_bit [*1] ##1 q.dout_oe)
    else $error("pending result not shown low");

  AST_MODE0_NO_COMBINED: assert property (
    s_select ##0 !i_ready_indication_mode |=> q.dout_bit)
    else $error("mode 0 signalled on combined pin");

  AST_RDATA_COPY: assert property (
    s_rdata_hit |=> (q.out_shift == $past(q.latest)) && (q.phase == sdr_pkg::SDR_RDATA))
    else $error("read-data copy mismatch");

  AST_PASS_UNCHANGED: assert property (
    out_if.valid && out_if.ready |=> q.latest == $past(out_if.data) && q.pending)
    else $error("result altered on capture");

  AST_TEMP_MODE: assert property (
    ##1 o_temp_sensor_select == $past(i_temp_sensor_mode))
    else $error("temperature mode not applied");

  AST_SHARED_CURRENT: assert property (
    ##1 (q.exc_one == q.exc_two) && (q.exc_one == $past(i_excitation_current_setting)))
    else $error("excitation sources differ");

  AST_READY_FALLS: assert property (
    $rose(q.pending) |-> $fell(q.ready_n))
    else $error("dedicated ready did not fall");

  AST_READ_CLEARS: assert property (
    fall && sel && (q.phase == sdr_pkg::SDR_DIRECT) && (q.bit_cnt == sdr_pkg::SDR_READ_LAST_BIT)
      |=> !q.pending ##1 q.ready_n)
    else $error("ready not cleared after read");

  // ========================================================================
  // shift and hand-over checks
  sequence s_shift_rise;
    rise && sel && (q.phase != sdr_pkg::SDR_WAIT);
  endsequence

  AST_OE_ON_SELECT: assert property (
    s_select |=> q.dout_oe)
    else $error("combined pin not driven after select");

  AST_DEDICATED_MIRRORS: assert property (
    q.ready_n == !q.pending)
    else $error("dedicated ready out of step with pending");

  AST_SHIFT_MSB_FIRST: assert property (
    s_shift_rise |=> q.dout_bit == $past(q.out_shift[15]))
    else $error("shifted bit is not the msb");

  AST_RDATA_CLEARS: assert property (
    fall && sel && (q.phase == sdr_pkg::SDR_RDATA) && (q.bit_cnt == sdr_pkg::SDR_READ_LAST_BIT)
      |=> !q.pending)
    else $error("ready not cleared after read-data");

  // a drain during a selection would tear the word being shifted
  AST_NO_DRAIN_SELECTED: assert property (
    !q.csn_s[1] |-> !out_if.ready)
    else $error("buffer drained while selected");

  AST_LATEST_HELD: assert property (
    sel |=> $stable(q.latest))
    else $error("latest result changed while selected");

  AST_DESELECT_TO_WAIT: assert property (
    !sel && (q.phase != sdr_pkg::SDR_WAIT) |=> (q.phase == sdr_pkg::SDR_WAIT))
    else $error("engine not idle after deselect");

  AST_MODE1_HIGH_NO_DATA: assert property (
    s_select ##0 (i_ready_indication_mode && !q.pending) |=> q.dout_bit)
    else $error("no result but combined pin low");

  AST_SOURCES_EQUAL: assert property (
    q.exc_one == q.exc_two)
    else $error("excitation sources not matched");

endmodule : sdr_ready_core
`default_nettype wire

// *** rtl/sdr_result_buf.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// two-entry result buffer; ready on the fill side is a flip-flop
module sdr_result_buf (
  input  wire logic   i_core_clk,
  input  wire logic   i_resetn,
  sdr_stream_if.snk   s_in,
  sdr_stream_if.src   s_out
);

  typedef struct packed {
    logic [sdr_pkg::SDR_BUF_DEPTH-1:0][sdr_pkg::SDR_DATA_W-1:0] mem;
    logic                                                      wptr;
    logic                                                      rptr;
    logic [1:0]                                                cnt;
    logic                                                      in_rdy;
    logic                                                      out_vld;
  } sdr_buf_t;

  sdr_buf_t q;
  sdr_buf_t next_q;
  logic     push;
  logic     pop;

  // ========================================================================
  // next state
  always_comb begin
    next_q = q;
    push   = s_in.valid & q.in_rdy;
    pop    = q.out_vld & s_out.ready;
    if (push) begin
      next_q.mem[q.wptr] = s_in.data;
      next_q.wptr        = ~q.wptr;
    end
    if (pop) begin
      next_q.rptr = ~q.rptr;
    end
    if (push && !pop) begin
      next_q.cnt = q.cnt + 2'h1;
    end else if (pop && !push) begin
      next_q.cnt = q.cnt - 2'h1;
    end
    next_q.in_rdy  = (next_q.cnt != sdr_pkg::SDR_BUF_FULL);
    next_q.out_vld = (next_q.cnt != sdr_pkg::SDR_BUF_EMPTY);
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q         <= '0;
      q.in_rdy  <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign s_in.ready  = q.in_rdy;
  assign s_out.valid = q.out_vld;
  assign s_out.data  = q.mem[q.rptr];

  // ========================================================================
  // checks
  AST_BUF_FULL_STALLS: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (q.cnt == sdr_pkg::SDR_BUF_FULL) |-> !q.in_rdy)
    else $error("buffer full but still accepting");
  AST_BUF_EMPTY_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (q.cnt == sdr_pkg::SDR_BUF_EMPTY) |-> !q.out_vld)
    else $error("buffer empty but presenting data");

endmodule : sdr_result_buf
`default_nettype wire

// *** test/sdr_spi_master.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// spi mode 1 master standing in for the microcontroller
module sdr_spi_master (
  input  wire logic i_core_clk,
  input  wire logic i_pin,
  input  wire logic i_pin_oe,
  output logic      o_spi_sclk,
  output logic      o_spi_csn_n,
  output logic      o_spi_din
);
  int   half = 4;
  logic last = 1'b1;

  initial begin
    o_spi_sclk  = 1'b0;
    o_spi_csn_n = 1'b1;
    o_spi_din   = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : wait_cyc

  // a released pin reads as the inverse of its last level, so a missing drive shows up
  task automatic bit_xfer(input logic tx, output logic rx);
    o_spi_sclk = 1'b1;
    o_spi_din  = tx;
    wait_cyc(half);
    o_spi_sclk = 1'b0;
    rx         = i_pin_oe ? i_pin : ~last;
    last       = rx;
    wait_cyc(half);
  endtask : bit_xfer

  task automatic select();
    o_spi_csn_n = 1'b0;
    wait_cyc(5);
  endtask : select

  task automatic deselect();
    wait_cyc(2);
    o_spi_csn_n = 1'b1;
    wait_cyc(5);
  endtask : deselect

  task automatic send8(input logic [7:0] cmd);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(cmd[i], r);
  endtask : send8

  task automatic get16(output logic [15:0] d);
    for (int i = 15; i >= 0; i--) bit_xfer(1'b1, d[i]);
  endtask : get16
endmodule : sdr_spi_master
`default_nettype wire

// *** test/spi_data_ready_signaling_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module spi_data_ready_signaling_test;
  logic        i_core_clk = 1'b0;
  logic        i_resetn   = 1'b0;
  logic        mode       = 1'b0;
  logic        ts         = 1'b0;
  logic        conv_valid = 1'b0;
  logic [2:0]  cur        = 3'h0;
  logic [15:0] cdata      = 16'h0000;
  logic [15:0] d;
  wire logic   sclk, csn_n, din, pin, pin_oe, rdy_n, ts_sel, conv_ready;
  wire logic [2:0] src1, src2;
  int          error_cnt  = 0;
  int          n_tests    = 0;

  always #2 i_core_clk = ~i_core_clk;

  sdr_ready_core i_sdr_ready_core (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_spi_sclk(sclk), .i_spi_csn_n(csn_n),
    .i_spi_din(din), .o_combined_dataout_ready_pin(pin), .o_combined_dataout_ready_pin_oe(pin_oe),
    .o_dedicated_ready_pin_n(rdy_n), .i_ready_indication_mode(mode), .i_temp_sensor_mode(ts),
    .i_excitation_current_setting(cur), .o_temp_sensor_select(ts_sel),
    .o_excitation_source_one(src1), .o_excitation_source_two(src2),
    .i_conv_valid(conv_valid), .i_conv_data(cdata), .o_conv_ready(conv_ready));

  sdr_spi_master i_sdr_spi_master (
    .i_core_clk(i_core_clk), .i_pin(pin), .i_pin_oe(pin_oe),
    .o_spi_sclk(sclk), .o_spi_csn_n(csn_n), .o_spi_din(din));

  // ==========================================================================
  // checking and closing
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // offered word is taken at the first rising edge that sees ready high
  task automatic push(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge i_core_clk);
    conv_valid = 1'b1;
    cdata      = w;
    while (conv_ready !== 1'b1 && n < 50) begin
      @(negedge i_core_clk);
      n++;
    end
    @(negedge i_core_clk);
    conv_valid = 1'b0;
  endtask : push

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk_bit(pin_oe, 1'b0);
    chk_bit(rdy_n, 1'b1);
    chk_bit(conv_ready, 1'b1);
    chk_word({10'h000, src1, src2}, 16'h0000);
  endtask : t_reset

  task automatic t_config();
    for (int k = 0; k < 8; k++) begin
      @(negedge i_core_clk);
      cur = k[2:0];
      ts  = k[0];
      i_sdr_spi_master.wait_cyc(3);
      chk_word({10'h000, src1, src2}, {10'h000, k[2:0], k[2:0]});
      chk_bit(ts_sel, k[0]);
    end
  endtask : t_config

  task automatic t_mode0_poll();
    mode = 1'b0;
    push(16'hA5C3);
    i_sdr_spi_master.wait_cyc(4);
    chk_bit(rdy_n, 1'b0);
    chk_bit(pin_oe, 1'b0);
    i_sdr_spi_master.select();
    chk_bit(pin_oe, 1'b1);
    chk_bit(pin, 1'b1);
    i_sdr_spi_master.deselect();
    chk_bit(pin_oe, 1'b0);
    chk_bit(rdy_n, 1'b0);
  endtask : t_mode0_poll

  task automatic t_direct_read();
    mode = 1'b1;
    i_sdr_spi_master.select();
    chk_bit(pin_oe, 1'b1);
    chk_bit(pin, 1'b0);
    i_sdr_spi_master.get16(d);
    chk_word(d, 16'hA5C3);
    i_sdr_spi_master.wait_cyc(2);
    chk_bit(rdy_n, 1'b1);
    i_sdr_spi_master.get16(d);
    chk_word(d, 16'hFFFF);
    chk_bit(pin, 1'b1);
    i_sdr_spi_master.deselect();
    chk_bit(pin_oe, 1'b0);
  endtask : t_direct_read

  task automatic t_rdata();
    mode                    = 1'b0;
    i_sdr_spi_master.half   = 7;
    i_sdr_spi_master.select();
    i_sdr_spi_master.send8(sdr_pkg::SDR_CMD_READ_DATA);
    i_sdr_spi_master.get16(d);
    chk_word(d, 16'hA5C3);
    i_sdr_spi_master.deselect();
    i_sdr_spi_master.half   = 4;
    chk_bit(rdy_n, 1'b1);
  endtask : t_rdata

  // selected core drains nothing, so two words fill the buffer and the newest wins
  task automatic t_buffer();
    mode = 1'b1;
    i_sdr_spi_master.select();
    chk_bit(pin, 1'b1);
    push(16'h1234);
    push(16'h8E71);
    i_sdr_spi_master.wait_cyc(4);
    chk_bit(conv_ready, 1'b0);
    chk_bit(rdy_n, 1'b1);
    i_sdr_spi_master.deselect();
    i_sdr_spi_master.wait_cyc(10);
    chk_bit(rdy_n, 1'b0);
    chk_bit(conv_ready, 1'b1);
    chk_bit(pin_oe, 1'b0);
    i_sdr_spi_master.select();
    chk_bit(pin, 1'b0);
    i_sdr_spi_master.get16(d);
    chk_word(d, 16'h8E71);
    i_sdr_spi_master.get16(d);
    chk_word(d, 16'hFFFF);
    i_sdr_spi_master.deselect();
  endtask : t_buffer

  initial begin
    repeat (10) @(negedge i_core_clk);
    i_resetn = 1'b1;
    @(negedge i_core_clk);
    t_reset();
    t_config();
    t_mode0_poll();
    t_direct_read();
    t_rdata();
    t_buffer();
    print_verdict();
  end

  // whole run needs about a thousand cycles; this allows about thirty times that
  initial begin
    #120000;
    error_cnt++;
    print_verdict();
  end
endmodule : spi_data_ready_signaling_test
`default_nettype wire
